// file: vrt_defs.svh
`ifndef VRT_DEFS_SVH
`define VRT_DEFS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define VRT_OFS_TIMING      4'h0
`define VRT_OFS_STATUS      4'h4
`define VRT_OFS_ERROR       4'h8
// ****************************************
// timing register fields and reset values
// ****************************************
`define VRT_TIM_ENTRY_LSB   0
`define VRT_TIM_EXIT_LSB    8
`define VRT_ENTRY_DLY_RST   8'h08
`define VRT_EXIT_DLY_RST    8'h08
// ****************************************
// status register fields
// ****************************************
`define VRT_ST_ON           0
`define VRT_ST_ENTRY        1
`define VRT_ST_EXIT         2
`define VRT_ST_LIVE_LSB     8
`define VRT_ST_OPER_LSB     16
`define VRT_ST_OPER_VALID   23
// ****************************************
// error register bits (write one to clear)
// ****************************************
`define VRT_ERR_EARLY       0
`define VRT_ERR_ILLEGAL     1
`define VRT_ERR_EXIT        2
`define VRT_ERR_RANGE       3
`define VRT_ERR_RSVD        4
`define VRT_ERR_DEVADDR     5
`define VRT_ERR_W           6
// ****************************************
// mode register six layout and decode
// ****************************************
`define VRT_MR_EN_BIT       7
`define VRT_MR_RANGE_BIT    6
`define VRT_TRAIN_REG_BA    2'h2
`define VRT_CODE_RSVD_MIN   6'h33
`define VRT_SYNC_RST        17'h0_0000
`endif

// file: vrt_pkg.sv
package vrt_pkg;
  typedef enum logic [2:0] {
    VRT_DES, VRT_ACT, VRT_WR, VRT_RD, VRT_PRE, VRT_MRS, VRT_OTHER
  } vrt_cmd_t;

  typedef enum logic [1:0] {
    VRT_IDLE, VRT_ENTRY_WAIT, VRT_ACTIVE, VRT_EXIT_WAIT
  } vrt_mode_t;

  typedef struct packed {
    logic       mclk;
    logic       cs_n;
    logic       act_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       bg0;
    logic [1:0] ba;
    logic [7:0] addr;
  } vrt_pins_t;

  typedef struct packed {
    vrt_pins_t   s1;
    vrt_pins_t   s2;
    vrt_pins_t   s3;
    vrt_pins_t   filt;
    logic        clk_prev;
    vrt_mode_t   mode;
    logic        train_on;
    logic [7:0]  cnt;
    logic        mr_range;
    logic [5:0]  mr_code;
    logic        op_range;
    logic [5:0]  op_code;
    logic        op_valid;
    logic [7:0]  entry_dly;
    logic [7:0]  exit_dly;
    logic [5:0]  err;
    logic        ack;
    logic [31:0] rdata;
  } vrt_state_t;
endpackage

// file: vrt_training.sv
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "vrt_defs.svh"
module vrt_training
  import vrt_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic        I_MCLK,
  input  wire logic        I_CS_N,
  input  wire logic        I_ACT_N,
  input  wire logic        I_RAS_N,
  input  wire logic        I_CAS_N,
  input  wire logic        I_WE_N,
  input  wire logic        I_BG0,
  input  wire logic [1:0]  I_BA,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic        I_PER_DEV_ADDR,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_TRAIN_ON,
  output logic             O_TRAIN_RANGE,
  output logic [5:0]       O_TRAIN_CODE,
  output logic             O_REF_RANGE,
  output logic [5:0]       O_REF_CODE,
  output logic             O_REF_VALID
);
  vrt_state_t st;
  vrt_state_t next_st;
  vrt_pins_t  pins_in;
  vrt_pins_t  dis;
  logic       mclk_rise;
  vrt_cmd_t   cmd;
  logic       is_train_reg;
  logic       bus_req;
  logic [5:0] err_set;
  logic [5:0] err_clr;

  // ****************************************
  // pin capture and command decode
  // ****************************************
  assign pins_in = '{mclk: I_MCLK, cs_n: I_CS_N, act_n: I_ACT_N, ras_n: I_RAS_N,
                     cas_n: I_CAS_N, we_n: I_WE_N, bg0: I_BG0, ba: I_BA, addr: I_ADDR};
  assign dis       = st.s2 ^ st.s3;
  assign mclk_rise = st.filt.mclk & ~st.clk_prev;

  always_comb begin
    if (st.filt.cs_n) begin
      cmd = VRT_DES;
    end else if (!st.filt.act_n) begin
      cmd = VRT_ACT;
    end else begin
      unique case ({st.filt.ras_n, st.filt.cas_n, st.filt.we_n})
        3'b000:  cmd = VRT_MRS;
        3'b010:  cmd = VRT_PRE;
        3'b100:  cmd = VRT_WR;
        3'b101:  cmd = VRT_RD;
        default: cmd = VRT_OTHER;
      endcase
    end
  end

  assign is_train_reg = (cmd == VRT_MRS) && st.filt.bg0 && (st.filt.ba == `VRT_TRAIN_REG_BA);
  assign bus_req = I_AVS_READ | I_AVS_WRITE;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st  = st;
    err_set  = '0;
    err_clr  = '0;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = vrt_pins_t'((st.s3 & ~dis) | (st.filt & dis));
    next_st.clk_prev = st.filt.mclk;

    if (mclk_rise) begin
      unique case (st.mode)
        VRT_IDLE: begin
          if (is_train_reg && st.filt.addr[`VRT_MR_EN_BIT]) begin
            next_st.mode     = VRT_ENTRY_WAIT;
            next_st.train_on = 1'b1;
            next_st.cnt      = st.entry_dly;
            next_st.mr_range = st.filt.addr[`VRT_MR_RANGE_BIT];
          end
        end
        VRT_ENTRY_WAIT: begin
          if (cmd != VRT_DES) begin
            err_set[`VRT_ERR_EARLY] = 1'b1;
          end
          if (st.cnt <= 8'h01) begin
            next_st.mode = VRT_ACTIVE;
          end else begin
            next_st.cnt = st.cnt - 8'h01;
          end
        end
        VRT_ACTIVE: begin
          if (is_train_reg && st.filt.addr[`VRT_MR_EN_BIT]) begin
            next_st.mr_code = st.filt.addr[5:0];
            if (st.filt.addr[`VRT_MR_RANGE_BIT] != st.mr_range) begin
              err_set[`VRT_ERR_RANGE] = 1'b1;
            end
            if (st.filt.addr[5:0] >= `VRT_CODE_RSVD_MIN) begin
              err_set[`VRT_ERR_RSVD] = 1'b1;
            end
          end else if (is_train_reg) begin
            next_st.mode     = VRT_EXIT_WAIT;
            next_st.train_on = 1'b0;
            next_st.cnt      = st.exit_dly;
            next_st.op_range = st.mr_range;
            next_st.op_code  = st.mr_code;
            next_st.op_valid = 1'b1;
          end else if (cmd == VRT_MRS || cmd == VRT_OTHER) begin
            err_set[`VRT_ERR_ILLEGAL] = 1'b1;
          end
          if (I_PER_DEV_ADDR && cmd != VRT_DES && cmd != VRT_MRS) begin
            err_set[`VRT_ERR_DEVADDR] = 1'b1;
          end
        end
        VRT_EXIT_WAIT: begin
          if (cmd != VRT_DES) begin
            err_set[`VRT_ERR_EXIT] = 1'b1;
          end
          if (st.cnt <= 8'h01) begin
            next_st.mode = VRT_IDLE;
          end else begin
            next_st.cnt = st.cnt - 8'h01;
          end
        end
      endcase
    end

    // avalon slave: one wait cycle, then the request is taken
    next_st.ack = bus_req & ~st.ack;
    if (bus_req && !st.ack) begin
      unique case (I_AVS_ADDRESS)
        `VRT_OFS_TIMING: next_st.rdata = {16'h0000, st.exit_dly, st.entry_dly};
        `VRT_OFS_STATUS: next_st.rdata = {8'h00, st.op_valid, st.op_range, st.op_code,
                                          1'b0, st.mr_range, st.mr_code, 5'h00,
                                          st.mode == VRT_EXIT_WAIT,
                                          st.mode == VRT_ENTRY_WAIT, st.train_on};
        `VRT_OFS_ERROR:  next_st.rdata = {26'h000_0000, st.err};
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (I_AVS_WRITE && st.ack) begin
      if (I_AVS_ADDRESS == `VRT_OFS_TIMING) begin
        next_st.entry_dly = I_AVS_WRITEDATA[`VRT_TIM_ENTRY_LSB +: 8];
        next_st.exit_dly  = I_AVS_WRITEDATA[`VRT_TIM_EXIT_LSB +: 8];
      end else if (I_AVS_ADDRESS == `VRT_OFS_ERROR) begin
        err_clr = I_AVS_WRITEDATA[`VRT_ERR_W-1:0];
      end
    end
    // a new error wins over a clear in the same cycle
    next_st.err = (st.err & ~err_clr) | err_set;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st           <= '0;
      st.s1        <= `VRT_SYNC_RST;
      st.mode      <= VRT_IDLE;
      st.entry_dly <= `VRT_ENTRY_DLY_RST;
      st.exit_dly  <= `VRT_EXIT_DLY_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_AVS_READDATA    = st.rdata;
  assign O_AVS_WAITREQUEST = bus_req & ~st.ack;
  assign O_TRAIN_ON        = st.train_on;
  assign O_TRAIN_RANGE     = st.mr_range;
  assign O_TRAIN_CODE      = st.mr_code;
  assign O_REF_RANGE       = st.op_range;
  assign O_REF_CODE        = st.op_code;
  assign O_REF_VALID       = st.op_valid;

  // ****************************************
  // assertions
  // ****************************************
  a_entry_takes_range: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_IDLE && is_train_reg && st.filt.addr[7])
    |=> (st.mode == VRT_ENTRY_WAIT && st.mr_range == $past(st.filt.addr[6])
         && $stable(st.mr_code) && st.train_on))
    else $error("entry did not start training");

  a_disable_keeps_bits: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && is_train_reg && !st.filt.addr[7]) |=> ($stable(st.mr_code) && $stable(st.mr_range)))
    else $error("enable-zero write changed the setting");

  a_exit_adopts_value: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && is_train_reg && !st.filt.addr[7])
    |=> (st.op_code == $past(st.mr_code) && st.op_range == $past(st.mr_range)
         && st.op_valid && !st.train_on && st.mode == VRT_EXIT_WAIT))
    else $error("exit did not adopt last value");

  a_value_write_code: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && is_train_reg && st.filt.addr[7])
    |=> (st.mr_code == $past(st.filt.addr[5:0]) && st.train_on))
    else $error("value write not stored");

  a_range_held: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (st.mode == VRT_ACTIVE && $past(st.mode) == VRT_ACTIVE) |-> $stable(st.mr_range))
    else $error("range changed inside training");

  a_early_cmd_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ENTRY_WAIT && cmd != VRT_DES) |=> st.err[0])
    else $error("early command not flagged");

  a_exit_wait_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_EXIT_WAIT && cmd != VRT_DES) |=> st.err[2])
    else $error("command in exit wait not flagged");

  a_reserved_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && is_train_reg && st.filt.addr[7]
     && st.filt.addr[5:0] >= 6'h33) |=> st.err[4])
    else $error("reserved code not flagged");

  a_bus_answer_time: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (bus_req && O_AVS_WAITREQUEST) |=> (!O_AVS_WAITREQUEST || !bus_req))
    else $error("waitrequest held too long");

  a_wait_first_cycle: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $rose(bus_req) |-> O_AVS_WAITREQUEST)
    else $error("request answered without a wait cycle");

  a_readdata_stands: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !(bus_req && !st.ack) |=> $stable(O_AVS_READDATA))
    else $error("read data changed without a new request");

  a_timing_write_lands: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == `VRT_OFS_TIMING)
    |=> (st.entry_dly == $past(I_AVS_WRITEDATA[7:0]) && st.exit_dly == $past(I_AVS_WRITEDATA[15:8])))
    else $error("timing write did not land");

  a_err_clear_w1c: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == `VRT_OFS_ERROR && err_set == 6'h00)
    |=> ((st.err & $past(I_AVS_WRITEDATA[5:0])) == 6'h00))
    else $error("error bits not cleared by a write of one");

  a_err_set_wins: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (err_set != 6'h00) |=> ((st.err & $past(err_set)) == $past(err_set)))
    else $error("new error lost");

  a_sync_takes_agreed: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (st.s2 == st.s3) |=> (st.filt == $past(st.s3)))
    else $error("filtered pins differ from agreed samples");

  a_idle_code_kept: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (st.mode == VRT_IDLE) |=> $stable(st.mr_code))
    else $error("value field taken outside training");

  a_train_on_mode: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    O_TRAIN_ON == (st.mode == VRT_ENTRY_WAIT || st.mode == VRT_ACTIVE))
    else $error("training flag out of step with mode");

  a_entry_count_down: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ENTRY_WAIT && st.cnt > 8'h01)
    |=> (st.mode == VRT_ENTRY_WAIT && st.cnt == $past(st.cnt) - 8'h01))
    else $error("entry delay not counted down");

  a_entry_wait_end: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ENTRY_WAIT && st.cnt <= 8'h01) |=> (st.mode == VRT_ACTIVE))
    else $error("entry delay did not end");

  a_exit_wait_end: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_EXIT_WAIT && st.cnt <= 8'h01) |=> (st.mode == VRT_IDLE))
    else $error("exit delay did not end");

  a_range_change_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && is_train_reg && st.filt.addr[7] && st.filt.addr[6] != st.mr_range)
    |=> st.err[3])
    else $error("range change not flagged");

  a_illegal_cmd_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && ((cmd == VRT_MRS && !is_train_reg) || cmd == VRT_OTHER)) |=> st.err[1])
    else $error("illegal training command not flagged");

  a_dev_addr_flag: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_ACTIVE && I_PER_DEV_ADDR && cmd != VRT_DES && cmd != VRT_MRS) |=> st.err[5])
    else $error("command under per-device addressing not flagged");

  a_ref_only_on_exit: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !(mclk_rise && st.mode == VRT_ACTIVE && is_train_reg && !st.filt.addr[7])
    |=> ($stable(st.op_code) && $stable(st.op_range)))
    else $error("operating reference changed outside exit");

  a_range_output: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (mclk_rise && st.mode == VRT_IDLE && is_train_reg && st.filt.addr[7])
    |=> (O_TRAIN_RANGE == $past(st.filt.addr[6])))
    else $error("range output does not follow entry bit");
endmodule // vrt_training
`default_nettype wire

// file: vrt_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// memory controller command driver
// ****************************************
module vrt_ctrl_model
  import vrt_pkg::*;
(
  input  wire logic      i_clock,
  output var  vrt_pins_t o_pins
);
  initial o_pins = 17'h0_F800;
  // one frame: low half then high half of a 160 ns clock, pins steady 80 ns each side
  task automatic issue(input vrt_cmd_t c, input logic [1:0] ba, input logic bg0, input logic [7:0] a);
    vrt_pins_t p;
    p = o_pins;
    p.mclk = 1'b0;
    p.cs_n = (c == VRT_DES);
    case (c)
      VRT_ACT: {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b0111;
      VRT_WR:  {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1100;
      VRT_RD:  {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1101;
      VRT_PRE: {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1010;
      VRT_MRS: {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1000;
      VRT_OTHER: {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1001;
      default: {p.act_n, p.ras_n, p.cas_n, p.we_n} = 4'b1111;
    endcase
    if (c == VRT_DES) begin
      // deselected ba and addr lines do not hold the last value; bg0 keeps it
      p.ba = ~o_pins.ba;
      p.addr = ~o_pins.addr;
    end else begin
      p.ba = ba;
      p.bg0 = bg0;
      p.addr = a;
    end
    // the clock stands high between frames; the next frame's falling edge moves the pins
    @(posedge i_clock);
    o_pins <= p;
    repeat (8) @(posedge i_clock);
    o_pins.mclk <= 1'b1;
    repeat (7) @(posedge i_clock);
  endtask
endmodule // vrt_ctrl_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import vrt_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        dev_addr = 1'b0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [3:0]  av_addr = 4'h0;
  logic [31:0] av_wdata = 32'h0000_0000;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        tr_on;
  logic        tr_rng;
  logic [5:0]  tr_code;
  logic        rf_rng;
  logic [5:0]  rf_code;
  logic        rf_vld;
  logic [31:0] rd;
  vrt_pins_t   pins;
  int          mismatches = 0;
  int          total_checks = 0;
  vrt_cmd_t    cl [4] = '{VRT_WR, VRT_ACT, VRT_RD, VRT_PRE};
  vrt_ctrl_model u_vrt_ctrl_model (.i_clock(clk), .o_pins(pins));
  vrt_training u_vrt_training (
    .I_CLOCK(clk), .I_RST(rst), .I_MCLK(pins.mclk), .I_CS_N(pins.cs_n), .I_ACT_N(pins.act_n),
    .I_RAS_N(pins.ras_n), .I_CAS_N(pins.cas_n), .I_WE_N(pins.we_n), .I_BG0(pins.bg0), .I_BA(pins.ba),
    .I_ADDR(pins.addr), .I_PER_DEV_ADDR(dev_addr), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd),
    .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(av_rdata),
    .O_AVS_WAITREQUEST(av_wait), .O_TRAIN_ON(tr_on), .O_TRAIN_RANGE(tr_rng), .O_TRAIN_CODE(tr_code),
    .O_REF_RANGE(rf_rng), .O_REF_CODE(rf_code), .O_REF_VALID(rf_vld));
  initial forever #5 clk = ~clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    av_addr <= a;
    av_wdata <= d;
    av_rd <= !w;
    av_wr <= w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (av_wait === 1'b0) break;
    end
    if (n == 20) begin
      mismatches++;
      test_done();
    end
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0000_0000, rd);
    chk(nm, e, rd);
  endtask
  task automatic train_wr(input logic [7:0] a);
    u_vrt_ctrl_model.issue(VRT_MRS, 2'h2, 1'b1, a);
  endtask
  task automatic des(input int n);
    repeat (n) u_vrt_ctrl_model.issue(VRT_DES, 2'h0, 1'b0, 8'h00);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdc("timing", 4'h0, 32'h0000_0808);
    rdc("status", 4'h4, 32'h0000_0000);
    rdc("error", 4'h8, 32'h0000_0000);
    avs(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
    rdc("unmapped", 4'hC, 32'h0000_0000);
    avs(1'b1, 4'h0, 32'h0000_0302, rd);
    rdc("timing", 4'h0, 32'h0000_0302);
    train_wr(8'hD5);
    chk("entry", 32'h0000_00C0, {24'h00_0000, tr_on, tr_rng, tr_code});
    rdc("status", 4'h4, 32'h0000_4003);
    des(3);
    foreach (cl[i]) u_vrt_ctrl_model.issue(cl[i], 2'h0, 1'b0, 8'h00);
    train_wr(8'hE0);
    chk("value", 32'h0000_00E0, {24'h00_0000, tr_on, tr_rng, tr_code});
    train_wr(8'hD0);
    rdc("status", 4'h4, 32'h0000_5001);
    des(1);
    train_wr(8'h7F);
    chk("oper", 32'h0000_00D0, {23'h00_0000, tr_on, rf_vld, rf_rng, rf_code});
    chk("kept", 32'h0000_0050, {25'h000_0000, tr_rng, tr_code});
    des(4);
    rdc("error", 4'h8, 32'h0000_0000);
    // faults of the controller, each flagged
    train_wr(8'h80);
    u_vrt_ctrl_model.issue(VRT_WR, 2'h0, 1'b0, 8'h00);
    des(3);
    train_wr(8'hC0);
    train_wr(8'hB3);
    u_vrt_ctrl_model.issue(VRT_MRS, 2'h0, 1'b0, 8'h00);
    u_vrt_ctrl_model.issue(VRT_OTHER, 2'h0, 1'b0, 8'h00);
    @(posedge clk) dev_addr <= 1'b1;
    u_vrt_ctrl_model.issue(VRT_ACT, 2'h0, 1'b0, 8'h00);
    @(posedge clk) dev_addr <= 1'b0;
    train_wr(8'h00);
    u_vrt_ctrl_model.issue(VRT_WR, 2'h0, 1'b0, 8'h00);
    des(4);
    rdc("error", 4'h8, 32'h0000_003F);
    avs(1'b1, 4'h8, 32'h0000_003F, rd);
    rdc("error", 4'h8, 32'h0000_0000);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
